// ===== logic/dfc_flow.sv
// Two-channel flow controller with CRC, null device, arbiter, abort
`timescale 1ns/100ps
module dfc_flow (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  input wire logic [8:0] per_src_rdy_i,
  input wire logic [8:0] per_dst_rdy_i,
  input wire logic [7:0] [8:0] per_src_data_i,
  output dfc_pkg::dfc_sel_t [1:0] chan_sel_o,
  output logic [1:0] chan_take_o,
  output dfc_pkg::dfc_byte_t bus_byte_o,
  output logic [1:0] chan_eof_o
);
  import dfc_pkg::*;

  typedef enum logic [2:0] {
    DFC_ST_IDLE = 3'b001,
    DFC_ST_LOAD = 3'b010,
    DFC_ST_RUN = 3'b100
  } dfc_chst_t;

  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] ctrl_q;
  logic [15:0] crc_q;
  logic crc_wph_q, crc_rph_q;
  logic [7:0] crc_lo_buf_q;
  logic last_gnt_q;
  logic null_ph_q [2];
  logic [7:0] null_lo_q [2];
  dfc_chst_t st_q [2];
  logic [2:0] dix_q [2];
  logic [3:0] src_q [2], dst_q [2], exp_q [2];
  logic [15:0] size_q [2], rem_q [2];
  logic [13:0] bcnt_q [2];
  logic pend_q [2], busy_q [2], eof_q [2], rph_q [2];
  logic [1:0] take_q;
  dfc_byte_t byte_q;

  wire wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
  wire rd_go = s_arvalid_i & ~rvalid_q;
  wire [7:0] wb = w_data_q[7:0];
  wire wr_lane0 = w_strb_q[0];
  wire wr_ctl = wr_go & wr_lane0 & (aw_addr_q == DFC_OFF_CTRL);
  wire wr_cc = wr_go & wr_lane0 & (aw_addr_q == DFC_OFF_CHCTL);
  wire wr_crc = wr_go & wr_lane0 & (aw_addr_q == DFC_OFF_CRC);
  wire rd_crc = rd_go & (s_araddr_i == DFC_OFF_CRC);
  wire wr_known = (aw_addr_q == DFC_OFF_CTRL) | (aw_addr_q == DFC_OFF_CHCTL)
    | (aw_addr_q == DFC_OFF_DESC0) | (aw_addr_q == DFC_OFF_DESC1)
    | (aw_addr_q == DFC_OFF_CRC);
  wire en = ctrl_q[DFC_CTL_EN];
  wire abtm = ctrl_q[DFC_CTL_ABTM];
  wire crc_enable_alias = ctrl_q[DFC_CTL_CRC_ENABLE_ALIAS];
  wire [1:0] prio = ctrl_q[DFC_CTL_PRIO_LO +: 2];
  wire crc_enable_alias_fall = wr_ctl & crc_enable_alias & ~wb[DFC_CTL_CRC_ENABLE_ALIAS];

  logic [1:0] srdy, drdy, want, gnt;
  logic [7:0] cbyte [2];
  logic [7:0] stat_w;
  logic [15:0] crc_next;

  // Ready and data selection per channel, with the null device
  for (genvar c = 0; c < 2; c++)
  begin : g_sel
    wire src_null = src_q[c] == DFC_ID_NULL;
    wire src_ok = src_q[c] <= DFC_ID_LAST;
    wire dst_null = dst_q[c] == DFC_ID_NULL;
    wire dst_ok = dst_q[c] <= DFC_ID_LAST;
    assign srdy[c] = src_null | (src_ok & per_src_rdy_i[src_q[c]]);
    assign drdy[c] = dst_null | (dst_ok & per_dst_rdy_i[dst_q[c]]);
    wire [7:0] per_byte;
    for (genvar b = 0; b < 8; b++)
    begin : g_bit
      assign per_byte[b] = per_src_data_i[b][src_ok ? src_q[c] : 4'h0];
    end
    assign cbyte[c] = src_null ? (null_ph_q[c] ? null_lo_q[c] : crc_q[15:8])
      : per_byte;
    // Moves only while running, enabled and both ends ready
    assign want[c] = en & (st_q[c] == DFC_ST_RUN) & srdy[c] & drdy[c];
    assign stat_w[c*DFC_ST_STRIDE +: DFC_ST_STRIDE] =
      {drdy[c], srdy[c], eof_q[c], busy_q[c]};
  end

  // Arbiter, re-evaluated every byte from the live priority field
  always_comb
  begin
    gnt = 2'b00;
    if (want == 2'b11)
    begin
      if (prio == DFC_PRIO_C0)
        gnt = 2'b01;
      else if (prio == DFC_PRIO_C1)
        gnt = 2'b10;
      else
        gnt = last_gnt_q ? 2'b01 : 2'b10;
    end
    else
      gnt = want;
  end

  // Bitwise CRC over one byte, MSB first, no inversion
  always_comb
  begin
    crc_next = crc_q;
    for (int i = 7; i >= 0; i--)
      crc_next = {crc_next[14:0], 1'b0}
        ^ ((crc_next[15] ^ cbyte[0][i]) ? DFC_CRC_POLY : 16'h0000);
  end

  // Bus slave handshake
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= DFC_RESP_OK;
    end
    else
    begin
      if (s_awvalid_i & ~aw_hold_q)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= {s_awaddr_i[7:2], 2'b00};
      end
      if (s_wvalid_i & ~w_hold_q)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_wdata_i;
        w_strb_q <= s_wstrb_i;
      end
      if (wr_go)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? DFC_RESP_OK : DFC_RESP_SLVERR;
      end
      else if (bvalid_q & s_bready_i)
        bvalid_q <= 1'b0;
    end
  end

  logic [7:0] rd_byte;
  logic rd_known;
  always_comb
  begin
    rd_known = 1'b1;
    rd_byte = 8'h00;
    case (s_araddr_i[7:2])
      DFC_OFF_CTRL[7:2]: rd_byte = ctrl_q;
      DFC_OFF_STAT[7:2]: rd_byte = stat_w;
      DFC_OFF_CHCTL[7:2]: rd_byte = 8'h00;
      DFC_OFF_DESC0[7:2]: rd_byte = rph_q[0] ? rem_q[0][7:0] : rem_q[0][15:8];
      DFC_OFF_DESC1[7:2]: rd_byte = rph_q[1] ? rem_q[1][7:0] : rem_q[1][15:8];
      DFC_OFF_CRC[7:2]: rd_byte = crc_rph_q ? crc_lo_buf_q : crc_q[15:8];
      default: rd_known = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= DFC_RESP_OK;
    end
    else if (rd_go)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= rd_known ? DFC_RESP_OK : DFC_RESP_SLVERR;
    end
    else if (rvalid_q & s_rready_i)
      rvalid_q <= 1'b0;
  end

  // Control register, CRC accumulator and its byte sequencing
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_q <= DFC_CTL_RST;
      crc_q <= DFC_CRC_RST;
      crc_wph_q <= 1'b0;
      crc_rph_q <= 1'b0;
      crc_lo_buf_q <= 8'h00;
      last_gnt_q <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
        ctrl_q <= wb & DFC_CTL_MASK;
      if (gnt != 2'b00)
        last_gnt_q <= gnt[1];
      if (wr_crc)
      begin
        crc_wph_q <= ~crc_wph_q;
        if (crc_wph_q)
          crc_q[7:0] <= wb;
        else
          crc_q[15:8] <= wb;
      end
      else if (gnt[0] & crc_enable_alias)
        crc_q <= crc_next;
      // High byte read latches low byte so the pair is coherent
      if (rd_crc)
      begin
        crc_rph_q <= ~crc_rph_q;
        if (!crc_rph_q)
          crc_lo_buf_q <= crc_q[7:0];
      end
      if (crc_enable_alias_fall)
      begin
        crc_wph_q <= 1'b0;
        crc_rph_q <= 1'b0;
      end
    end
  end

  // Per-channel descriptor loading, transfer counting and abort
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    localparam logic [7:0] DOFF = c ? DFC_OFF_DESC1 : DFC_OFF_DESC0;
    localparam int ABT = c ? DFC_CC_ABT1 : DFC_CC_ABT0;
    localparam int ACK = c ? DFC_CC_ACK1 : DFC_CC_ACK0;
    wire wr_d = wr_go & wr_lane0 & (aw_addr_q == DOFF);
    wire rd_d = rd_go & (s_araddr_i == DOFF);
    wire abt = wr_cc & wb[ABT];
    wire ack = wr_cc & wb[ACK];
    wire [3:0] e = (exp_q[c] > DFC_EXP_MAX) ? DFC_EXP_MAX : exp_q[c];
    wire [13:0] plast = 14'((15'h0001 << e) - 15'h0001);
    wire pkt_end = bcnt_q[c] == plast;
    wire flow_end = pkt_end & (size_q[c] != 16'h0000)
      & (rem_q[c] == 16'h0001);
    wire stop_now = pend_q[c] & (~abtm | pkt_end);
    always_ff @(posedge mclk_i)
    begin
      if (!rst_b_i)
      begin
        st_q[c] <= DFC_ST_IDLE;
        dix_q[c] <= 3'h0;
        src_q[c] <= 4'h0;
        dst_q[c] <= 4'h0;
        exp_q[c] <= 4'h0;
        size_q[c] <= 16'h0000;
        rem_q[c] <= 16'h0000;
        bcnt_q[c] <= 14'h0000;
        pend_q[c] <= 1'b0;
        busy_q[c] <= 1'b0;
        eof_q[c] <= 1'b0;
        rph_q[c] <= 1'b0;
        null_ph_q[c] <= 1'b0;
        null_lo_q[c] <= 8'h00;
      end
      else
      begin
        if (rd_d)
          rph_q[c] <= ~rph_q[c];
        // Set wins over acknowledge in the same cycle
        if (ack)
          eof_q[c] <= 1'b0;
        case (st_q[c])
          DFC_ST_IDLE, DFC_ST_LOAD:
          begin
            if (abt)
            begin
              st_q[c] <= DFC_ST_IDLE;
              dix_q[c] <= 3'h0;
              src_q[c] <= 4'h0;
              dst_q[c] <= 4'h0;
              exp_q[c] <= 4'h0;
              size_q[c] <= 16'h0000;
            end
            else if (wr_d)
            begin
              case (dix_q[c])
                3'h0: src_q[c] <= wb[3:0];
                3'h1: dst_q[c] <= wb[3:0];
                3'h2: exp_q[c] <= wb[3:0];
                3'h3: size_q[c][15:8] <= wb;
                default: size_q[c][7:0] <= wb;
              endcase
              if (dix_q[c] == DFC_DESC_LAST)
              begin
                st_q[c] <= DFC_ST_RUN;
                dix_q[c] <= 3'h0;
                busy_q[c] <= 1'b1;
                rem_q[c] <= {size_q[c][15:8], wb};
                bcnt_q[c] <= 14'h0000;
                null_ph_q[c] <= 1'b0;
                rph_q[c] <= 1'b0;
              end
              else
              begin
                st_q[c] <= DFC_ST_LOAD;
                dix_q[c] <= dix_q[c] + 3'h1;
              end
            end
          end
          DFC_ST_RUN:
          begin
            if (abt)
              pend_q[c] <= 1'b1;
            if (gnt[c])
            begin
              null_ph_q[c] <= ~null_ph_q[c];
              // Low half kept so the CRC update cannot change it mid-pair
              if (!null_ph_q[c])
                null_lo_q[c] <= crc_q[7:0];
              bcnt_q[c] <= pkt_end ? 14'h0000 : bcnt_q[c] + 14'h0001;
              if (pkt_end)
                rem_q[c] <= rem_q[c] - 16'h0001;
              if (flow_end | stop_now)
              begin
                st_q[c] <= DFC_ST_IDLE;
                busy_q[c] <= 1'b0;
                eof_q[c] <= 1'b1;
                pend_q[c] <= 1'b0;
              end
            end
            else if (stop_now & ~abtm)
            begin
              st_q[c] <= DFC_ST_IDLE;
              busy_q[c] <= 1'b0;
              eof_q[c] <= 1'b1;
              pend_q[c] <= 1'b0;
            end
          end
          default: st_q[c] <= DFC_ST_IDLE;
        endcase
      end
    end
    assign chan_sel_o[c] = '{src: src_q[c], dst: dst_q[c]};
    assign chan_eof_o[c] = eof_q[c];
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      take_q <= 2'b00;
      byte_q <= '0;
    end
    else
    begin
      take_q <= gnt;
      byte_q.valid <= gnt != 2'b00;
      byte_q.data <= gnt[1] ? cbyte[1] : cbyte[0];
    end
  end

  assign s_awready_o = ~aw_hold_q;
  assign s_wready_o = ~w_hold_q;
  assign s_bvalid_o = bvalid_q;
  assign s_bresp_o = bresp_q;
  assign s_arready_o = ~rvalid_q;
  assign s_rvalid_o = rvalid_q;
  assign s_rdata_o = rdata_q;
  assign s_rresp_o = rresp_q;
  assign chan_take_o = take_q;
  assign bus_byte_o = byte_q;

  // Checks
  property p_busy_eof;
    @(posedge mclk_i) disable iff (!rst_b_i)
      $fell(busy_q[0]) |-> eof_q[0];
  endproperty
  a_busy_eof: assert property (p_busy_eof)
    else $error("busy fell without end-of-flow");
  property p_crc_ch1;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (gnt == 2'b10) && !wr_crc |=> $stable(crc_q);
  endproperty
  a_crc_ch1: assert property (p_crc_ch1)
    else $error("crc moved on channel 1 traffic");
  property p_prio0;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (want == 2'b11) && (prio == DFC_PRIO_C0) |-> gnt == 2'b01;
  endproperty
  a_prio0: assert property (p_prio0)
    else $error("favoured channel lost");
  property p_alt;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (want == 2'b11) && (prio == DFC_PRIO_EQ) |-> gnt[0] == last_gnt_q;
  endproperty
  a_alt: assert property (p_alt)
    else $error("equal priority did not alternate");
  property p_grant_ready;
    @(posedge mclk_i) disable iff (!rst_b_i)
      gnt[1] |-> srdy[1] && drdy[1] && busy_q[1];
  endproperty
  a_grant_ready: assert property (p_grant_ready)
    else $error("grant without both ends ready");
  property p_imm_abort;
    @(posedge mclk_i) disable iff (!rst_b_i)
      pend_q[1] && !abtm |=> !busy_q[1];
  endproperty
  a_imm_abort: assert property (p_imm_abort)
    else $error("immediate abort did not stop");
  wire abt_w0 = wr_cc & wb[DFC_CC_ABT0];
  property p_load_abort;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (st_q[0] == DFC_ST_LOAD) && abt_w0 && !eof_q[0] |=> !eof_q[0]
        && !busy_q[0] && dix_q[0] == 3'h0;
  endproperty
  a_load_abort: assert property (p_load_abort)
    else $error("descriptor abort misbehaved");
  property p_crc_reset;
    @(posedge mclk_i) !rst_b_i |=> crc_q == DFC_CRC_RST;
  endproperty
  a_crc_reset: assert property (p_crc_reset)
    else $error("crc not zero after reset");
endmodule

// ===== logic/dfc_pkg.sv
// Package for the two-channel flow controller: map, fields, codes
package dfc_pkg;
  localparam logic [7:0] DFC_OFF_CTRL = 8'h00;
  localparam logic [7:0] DFC_OFF_STAT = 8'h04;
  localparam logic [7:0] DFC_OFF_CHCTL = 8'h08;
  localparam logic [7:0] DFC_OFF_DESC0 = 8'h0c;
  localparam logic [7:0] DFC_OFF_DESC1 = 8'h10;
  localparam logic [7:0] DFC_OFF_CRC = 8'h14;
  // Control register fields
  localparam int DFC_CTL_EN = 0;
  localparam int DFC_CTL_ABTM = 1;
  localparam int DFC_CTL_PRIO_LO = 2;
  localparam int DFC_CTL_CRC_ENABLE_ALIAS = 4;
  localparam logic [7:0] DFC_CTL_RST = 8'h00;
  localparam logic [7:0] DFC_CTL_MASK = 8'h1f;
  // Channel control fields: abort bits and flag acknowledge bits
  localparam int DFC_CC_ABT0 = 0;
  localparam int DFC_CC_ABT1 = 4;
  localparam int DFC_CC_ACK0 = 1;
  localparam int DFC_CC_ACK1 = 5;
  // Status fields per channel c at base 4*c
  localparam int DFC_ST_BSY = 0;
  localparam int DFC_ST_EOF = 1;
  localparam int DFC_ST_SRDY = 2;
  localparam int DFC_ST_DRDY = 3;
  localparam int DFC_ST_STRIDE = 4;
  localparam logic [1:0] DFC_PRIO_EQ = 2'h0;
  localparam logic [1:0] DFC_PRIO_C0 = 2'h1;
  localparam logic [1:0] DFC_PRIO_C1 = 2'h2;
  localparam logic [3:0] DFC_ID_NULL = 4'hf;
  localparam logic [3:0] DFC_ID_LAST = 4'h8;
  localparam logic [3:0] DFC_EXP_MAX = 4'hd;
  localparam logic [2:0] DFC_DESC_LAST = 3'h4;
  localparam logic [15:0] DFC_CRC_POLY = 16'h8005;
  localparam logic [15:0] DFC_CRC_RST = 16'h0000;
  localparam logic [1:0] DFC_RESP_OK = 2'h0;
  localparam logic [1:0] DFC_RESP_SLVERR = 2'h2;
  // Per-channel peripheral selection carried to the data path
  typedef struct packed {
    logic [3:0] src;
    logic [3:0] dst;
  } dfc_sel_t;
  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } dfc_byte_t;
endpackage

// ===== dv/dfc_periph_model.sv
// Peripheral controllers behind the flow controller: ready levels and data
`timescale 1ns/100ps
module dfc_periph_model (
  input wire logic mclk_i,
  input wire logic [8:0] src_en_i,
  input wire logic [8:0] dst_en_i,
  input wire logic [8:0] jit_i,
  input wire dfc_pkg::dfc_sel_t [1:0] sel_i,
  input wire logic [1:0] take_i,
  output logic [8:0] src_rdy_o,
  output logic [8:0] dst_rdy_o,
  output logic [7:0] [8:0] src_data_o
);
  import dfc_pkg::*;
  logic [7:0] cnt_q [9];
  logic [7:0] cur [9];
  logic [7:0] adv [9];
  assign src_rdy_o = src_en_i & jit_i;
  assign dst_rdy_o = dst_en_i & jit_i;
  initial
  begin
    foreach (cnt_q[i])
      cnt_q[i] = 8'h00;
  end
  // A source steps its stream only once the controller reports the take
  always @(posedge mclk_i)
  begin
    for (int c = 0; c < 2; c++)
      if (take_i[c] && sel_i[c].src < 4'h9)
        cnt_q[sel_i[c].src] <= cnt_q[sel_i[c].src] + 8'h01;
  end
  // A source that is not ready shows inverted data, so a stray sample shows
  // A reported take is shown at once, so a back-to-back grant gets a new byte
  always_comb
  begin
    for (int i = 0; i < 9; i++)
    begin
      adv[i] = 8'h00;
      for (int c = 0; c < 2; c++)
        if (take_i[c] && sel_i[c].src == 4'(i))
          adv[i] = adv[i] + 8'h01;
      cur[i] = 8'(i * 16) + cnt_q[i] + adv[i];
      for (int b = 0; b < 8; b++)
        src_data_o[b][i] = src_rdy_o[i] ? cur[i][b] : ~cur[i][b];
    end
  end
endmodule

// ===== dv/dfc_flow_tb_top.sv
// Self-checking bench for the two-channel flow controller
`timescale 1ns/100ps
module dfc_flow_tb_top;
  import dfc_pkg::*;
  logic mclk_i, rst_b_i, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, fr;
  logic [7:0] awaddr, araddr, g, h, e0, e1, eb;
  logic [31:0] wdata, rdata, rs;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, take, eof;
  logic [8:0] src_en, dst_en, jit, srdy, drdy;
  logic [7:0] [8:0] sdata;
  logic [15:0] r, x;
  dfc_sel_t [1:0] sel;
  dfc_byte_t bbyte;
  int n_errors, checked, tmo, n0;
  int mc [2];
  logic [7:0] pc [9];
  logic [10:0] rq [$];
  logic [1:0] bq [$];
  logic [7:0] eq0 [$];
  logic [7:0] eq1 [$];
  logic tk [$];

  dfc_flow i_dfc_flow (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
    .s_wdata_i(wdata), .s_wstrb_i(wstrb), .s_wvalid_i(wvalid),
    .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid),
    .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
    .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp),
    .s_rvalid_o(rvalid), .s_rready_i(rready), .per_src_rdy_i(srdy),
    .per_dst_rdy_i(drdy), .per_src_data_i(sdata), .chan_sel_o(sel),
    .chan_take_o(take), .bus_byte_o(bbyte), .chan_eof_o(eof));
  dfc_periph_model i_dfc_periph_model (.mclk_i(mclk_i), .src_en_i(src_en),
    .dst_en_i(dst_en), .jit_i(jit), .sel_i(sel), .take_i(take),
    .src_rdy_o(srdy), .dst_rdy_o(drdy), .src_data_o(sdata));

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  function automatic logic [15:0] crc(input logic [15:0] c,
    input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction

  function automatic logic [7:0] pb(input int id);
    pb = 8'(id * 16) + pc[id];
    pc[id]++;
  endfunction

  function automatic logic [1:0] rsp(input logic [7:0] a);
    return (a > DFC_OFF_CRC || a[1:0] != 2'h0) ? DFC_RESP_SLVERR : DFC_RESP_OK;
  endfunction

  task automatic chk(input string nm, input logic [15:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Address and data go out together; each is dropped once it is taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ah, wh, bh;
    @(posedge mclk_i);
    bq.push_back(rsp(a));
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bh = 1'b0;
    while (!bh)
    begin
      @(negedge mclk_i);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      @(posedge mclk_i);
      if (ah)
        awvalid <= 1'b0;
      if (wh)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, e, input logic dc,
    output logic [7:0] got);
    logic ah, rh;
    @(posedge mclk_i);
    rq.push_back({dc, rsp(a), e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rh = 1'b0;
    while (!rh)
    begin
      @(negedge mclk_i);
      ah = arvalid && arready;
      rh = rvalid;
      got = rdata[7:0];
      @(posedge mclk_i);
      if (ah)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic ctl(input logic [1:0] p, input logic ce, am);
    wr(DFC_OFF_CTRL, {3'h0, ce, p, am, 1'b1});
  endtask

  task automatic desc(input int c, input logic [3:0] s, d, xp,
    input logic [15:0] n);
    logic [7:0] a;
    a = c ? DFC_OFF_DESC1 : DFC_OFF_DESC0;
    wr(a, {4'h0, s});
    wr(a, {4'h0, d});
    wr(a, {4'h0, xp});
    wr(a, n[15:8]);
    wr(a, n[7:0]);
  endtask

  task automatic st(input logic [7:0] e, m);
    logic [7:0] v;
    rd(DFC_OFF_STAT, 8'h00, 1'b1, v);
    chk("status", v & m, e);
  endtask

  task automatic idle(input int c);
    logic [7:0] v;
    for (int i = 0; i < 400; i++)
    begin
      rd(DFC_OFF_STAT, 8'h00, 1'b1, v);
      if (!v[4 * c])
        break;
    end
  endtask

  // Random readiness of every peripheral while a free-running flow is on
  always @(posedge mclk_i)
  begin
    rs <= xs(rs);
    jit <= fr ? rs[8:0] : 9'h1ff;
  end

  always @(negedge mclk_i)
  begin
    tmo++;
    if (tmo > 60000)
    begin
      n_errors++;
      test_done;
    end
    if (bvalid && bready)
      chk("bresp", bresp, bq.size() ? bq.pop_front() : 2'h3);
    if (rvalid && rready)
    begin
      rq.push_front(rq.size() ? rq.pop_front() : 11'h3ff);
      chk("rresp", rresp, rq[0][9:8]);
      if (!rq[0][10])
        chk("rdata", rdata[7:0], rq[0][7:0]);
      void'(rq.pop_front());
    end
    if (bbyte.valid)
    begin
      tk.push_back(take[1]);
      mc[take[1]]++;
      if (take[1] ? eq1.size() : eq0.size())
      begin
        eb = take[1] ? eq1.pop_front() : eq0.pop_front();
        chk("byte", bbyte.data, eb);
      end
      else if (!fr)
        chk("unexpected byte", 1'b1, 1'b0);
    end
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, fr} = '0;
    {awaddr, araddr, wdata, src_en, dst_en, mc[0], mc[1]} = '0;
    wstrb = 4'h1;
    rs = 32'hd280;
    jit = 9'h1ff;
    foreach (pc[i])
      pc[i] = 8'h00;
    rst_b_i = 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd(DFC_OFF_CTRL, DFC_CTL_RST, 1'b0, g);
    rd(DFC_OFF_STAT, 8'h00, 1'b0, g);
    wr(8'h40, 8'h00);
    rd(8'h40, 8'h00, 1'b1, g);
    rd(DFC_OFF_CRC, 8'h00, 1'b0, g);
    rd(DFC_OFF_CRC, 8'h00, 1'b0, g);
    $display("Test registers done");
    dst_en <= 9'h1ff;
    r = rs[15:0];
    ctl(DFC_PRIO_EQ, 1'b1, 1'b0);
    wr(DFC_OFF_CRC, 8'hab);
    ctl(DFC_PRIO_EQ, 1'b0, 1'b0);
    ctl(DFC_PRIO_EQ, 1'b1, 1'b0);
    wr(DFC_OFF_CRC, r[15:8]);
    wr(DFC_OFF_CRC, r[7:0]);
    rd(DFC_OFF_CRC, r[15:8], 1'b0, g);
    rd(DFC_OFF_CRC, r[7:0], 1'b0, g);
    eq0.push_back(r[15:8]);
    eq0.push_back(r[7:0]);
    x = crc(crc(r, r[15:8]), r[7:0]);
    desc(0, DFC_ID_NULL, DFC_ID_NULL, 4'h0, 16'h0002);
    idle(0);
    st(8'h02, 8'h03);
    rd(DFC_OFF_CRC, x[15:8], 1'b0, g);
    rd(DFC_OFF_CRC, x[7:0], 1'b0, g);
    wr(DFC_OFF_CHCTL, 8'h22);
    chk("null flow drained", eq0.size(), 0);
    $display("Test crc and null source done");
    for (int p = 0; p < 3; p++)
    begin
      src_en <= 9'h000;
      ctl(p[1:0], 1'b1, 1'b0);
      desc(0, 4'h1, 4'h2, 4'h1, 16'h0002);
      desc(1, 4'h3, DFC_ID_NULL, 4'h1, 16'h0002);
      for (int i = 0; i < 4; i++)
      begin
        e0 = pb(1);
        e1 = pb(3);
        eq0.push_back(e0);
        eq1.push_back(e1);
        x = crc(x, e0);
      end
      st(8'h99, 8'hff);
      tk.delete();
      src_en <= 9'h1ff;
      idle(0);
      idle(1);
      st(8'h22, 8'h33);
      chk("takes", tk.size(), 8);
      for (int i = 1; i < 8 && p == 0; i++)
        chk("alternate", tk[i] != tk[i - 1], 1'b1);
      for (int i = 0; i < 4 && p > 0; i++)
        chk("favoured", tk[i], p == 2);
      rd(DFC_OFF_CRC, x[15:8], 1'b0, g);
      rd(DFC_OFF_CRC, x[7:0], 1'b0, g);
      wr(DFC_OFF_CHCTL, 8'h22);
      $display("Test arbitration %0d done", p);
    end
    wr(DFC_OFF_DESC0, 8'h05);
    wr(DFC_OFF_DESC0, 8'h06);
    wr(DFC_OFF_CHCTL, 8'h01);
    st(8'h00, 8'h03);
    eq0.push_back(pb(5));
    desc(0, 4'h5, 4'h6, 4'h0, 16'h0001);
    idle(0);
    st(8'h02, 8'h03);
    wr(DFC_OFF_CHCTL, 8'h22);
    $display("Test partial descriptor abort done");
    for (int m = 0; m < 2; m++)
    begin
      fr = 1'b1;
      ctl(DFC_PRIO_EQ, 1'b0, m[0]);
      mc[1] = 0;
      desc(1, 4'h7, 4'h8, 4'h2, 16'd50);
      repeat (20) @(posedge mclk_i);
      wr(DFC_OFF_CHCTL, 8'h10);
      n0 = mc[1];
      idle(1);
      st(8'h20, 8'h30);
      chk("eof pin", eof, 2'b10);
      rd(DFC_OFF_DESC1, 8'h00, 1'b1, h);
      rd(DFC_OFF_DESC1, 8'h00, 1'b1, g);
      if (m == 1)
      begin
        chk("packet end", 16'(mc[1] % 4), 16'h0000);
        chk("remaining", {h, g}, 16'(50 - mc[1] / 4));
      end
      else
        chk("prompt stop", mc[1] - n0 < 2, 1'b1);
      wr(DFC_OFF_CHCTL, 8'h22);
      fr = 1'b0;
      $display("Test abort mode %0d done", m);
    end
    test_done;
  end
endmodule
